// File: rtl/put_tuning_regs.sv
/*
 * Port-1 USB tuning register bank: transmit emphasis and receive adjust
 * registers, reached by the serial-interface register port and, for the
 * drive field, by the link register access port. Drives decoded settings
 * to the analog front end.
 * Assumes the serial and link access front ends, the chirp indicator and
 * the factory store all sit on sys_clk_in.
 */
// Function
// - Emphasis register at 0x71 resets to 0x39; factory load may replace it.
// - Bit 6 of emphasis register enables charging port method 1.
// - Bits 5-4 select emphasis width 0.35 to 0.65 UI; reset 3.
// - Bit 3 enables high-speed transmit emphasis; reset 1.
// - Emphasis is forced off during chirp J or chirp K.
// - Bits 2-0 select emphasis level 0.5 to 4.0 dB; reset 1.
// - Receive adjust register at 0x72 resets to 0x92.
// - Bits 7-6 select open-drain drive strength 1 to 8 mA; reset 2.
// - Link-side writes to drive field apply only while repeater 1 is enabled.
// - Bits 2-0 select receive equalizer 0.06 to 3.35 dB; reset 2.
`timescale 1ns/10ps
`default_nettype none

module put_tuning_regs
    import put_pkg::*;
(
    input wire logic sys_clk_in,                      // 100 MHz system clock
    input wire logic rst_n_in,                        // Synchronous reset, active low
    input wire logic [PUT_AW-1:0] ser_addr_in,        // Serial port register offset
    input wire logic ser_wr_in,                       // Serial port write strobe
    input wire logic ser_rd_in,                       // Serial port read strobe
    input wire logic [PUT_DW-1:0] ser_wdata_in,       // Serial port write data
    output logic [PUT_DW-1:0] ser_rdata_out,          // Serial port read data
    output logic ser_rvalid_out,                      // Read data valid pulse
    input wire logic [PUT_AW-1:0] link_addr_in,       // Link access register offset
    input wire logic link_wr_in,                      // Link access write strobe
    input wire logic [PUT_DW-1:0] link_wdata_in,      // Link access write data
    output logic link_wr_taken_out,                   // Link write applied pulse
    input wire logic repeater1_enable_in,             // Repeater 1 enabled level
    input wire logic otp_load_in,                     // Factory defaults load strobe
    input wire logic [PUT_DW-1:0] otp_tx_emph_in,     // Factory value for 0x71
    input wire logic [PUT_DW-1:0] otp_rx_adj_in,      // Factory value for 0x72
    input wire logic chirp_active_in,                 // Chirp J or K being sent
    output logic port1_charging_method1_enable_out,   // Charging port method 1 on
    output logic port1_hs_tx_emphasis_on_out,         // Emphasis active to driver
    output logic [1:0] port1_hs_tx_emphasis_width_out, // Width code
    output logic [6:0] emphasis_width_parameter_out,  // Width, 0.01 UI units
    output logic [2:0] port1_hs_tx_emphasis_level_out, // Level code
    output logic [8:0] emphasis_level_parameter_out,  // Level, 0.01 dB units
    output logic [1:0] open_drain_drive_strength_out, // Drive strength code
    output logic [3:0] drive_current_ma_out,          // Drive strength, mA
    output logic [2:0] port1_rx_equalizer_level_out,  // Equalizer code
    output logic [8:0] rx_equalizer_cdb_out           // Equalizer, 0.01 dB units
);

    logic [PUT_DW-1:0] emph_val;
    logic [PUT_DW-1:0] rxadj_val;

    logic ser_wr_emph;
    logic ser_wr_rxadj;
    logic link_wr_rxadj;

    // Serial port decode
    always_comb begin
        ser_wr_emph = 1'b0;
        ser_wr_rxadj = 1'b0;
        if (ser_addr_in == PUT_TX_EMPH_OFS) begin
            ser_wr_emph = ser_wr_in;
        end else if (ser_addr_in == PUT_RX_ADJ_OFS) begin
            ser_wr_rxadj = ser_wr_in;
        end
    end

    // Link writes reach only the drive field, and only with repeater 1 up
    always_comb begin
        link_wr_rxadj = 1'b0;
        if (link_addr_in == PUT_RX_ADJ_OFS) begin
            link_wr_rxadj = link_wr_in & repeater1_enable_in;
        end
    end

    assign link_wr_taken_out = link_wr_rxadj;

    // Emphasis register; reserved bit 7 is stored as written
    put_cfg_reg #(
        .RESET_VAL(PUT_TX_EMPH_RST)
    ) u_emph (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(otp_load_in),
        .load_val_in(otp_tx_emph_in),
        .a_wr_in(ser_wr_emph),
        .a_mask_in(PUT_ALL_MASK),
        .a_data_in(ser_wdata_in),
        .b_wr_in(1'b0),
        .b_mask_in(PUT_NO_MASK),
        .b_data_in(PUT_NO_MASK),
        .value_out(emph_val)
    );

    // Receive adjust register; serial port wins a same-cycle collision
    put_cfg_reg #(
        .RESET_VAL(PUT_RX_ADJ_RST)
    ) u_rxadj (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(otp_load_in),
        .load_val_in(otp_rx_adj_in),
        .a_wr_in(ser_wr_rxadj),
        .a_mask_in(PUT_ALL_MASK),
        .a_data_in(ser_wdata_in),
        .b_wr_in(link_wr_rxadj),
        .b_mask_in(PUT_DRIVE_MASK),
        .b_data_in(link_wdata_in),
        .value_out(rxadj_val)
    );

    // Read path
    logic [PUT_DW-1:0] rdata_q;
    logic [PUT_DW-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = ser_rd_in;
        if (ser_rd_in) begin
            if (ser_addr_in == PUT_TX_EMPH_OFS) begin
                rdata_d = emph_val;
            end else if (ser_addr_in == PUT_RX_ADJ_OFS) begin
                rdata_d = rxadj_val;
            end else begin
                rdata_d = PUT_UNMAPPED_RD;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= PUT_UNMAPPED_RD;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign ser_rdata_out = rdata_q;
    assign ser_rvalid_out = rvalid_q;

    // Field extraction
    logic chg_f;
    logic pe_on_f;
    logic [1:0] width_f;
    logic [2:0] level_f;
    logic [1:0] drive_f;
    logic [2:0] eq_f;

    assign chg_f = emph_val[PUT_CHG_BIT];
    assign width_f = emph_val[PUT_WIDTH_MSB:PUT_WIDTH_LSB];
    assign pe_on_f = emph_val[PUT_PE_ON_BIT];
    assign level_f = emph_val[PUT_LEVEL_MSB:PUT_LEVEL_LSB];
    assign drive_f = rxadj_val[PUT_DRIVE_MSB:PUT_DRIVE_LSB];
    assign eq_f = rxadj_val[PUT_EQ_MSB:PUT_EQ_LSB];

    // Registered settings to the analog side
    logic chg_q;
    logic chg_d;
    logic pe_on_q;
    logic pe_on_d;
    logic [1:0] width_q;
    logic [1:0] width_d;
    logic [6:0] width_cui_q;
    logic [6:0] width_cui_d;
    logic [2:0] level_q;
    logic [2:0] level_d;
    logic [8:0] level_cdb_q;
    logic [8:0] level_cdb_d;
    logic [1:0] drive_q;
    logic [1:0] drive_d;
    logic [3:0] drive_ma_q;
    logic [3:0] drive_ma_d;
    logic [2:0] eq_q;
    logic [2:0] eq_d;
    logic [8:0] eq_cdb_q;
    logic [8:0] eq_cdb_d;

    always_comb begin
        chg_d = chg_f;
        // Chirp overrides the enable so chirp amplitude stays clean
        pe_on_d = pe_on_f & ~chirp_active_in;
        width_d = width_f;
        width_cui_d = PUT_WIDTH_CUI[width_f];
        level_d = level_f;
        level_cdb_d = PUT_LEVEL_CDB[level_f];
        drive_d = drive_f;
        drive_ma_d = PUT_DRIVE_MA[drive_f];
        eq_d = eq_f;
        eq_cdb_d = PUT_EQ_CDB[eq_f];
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            chg_q <= PUT_TX_EMPH_RST[PUT_CHG_BIT];
            pe_on_q <= 1'b0;
            width_q <= PUT_TX_EMPH_RST[PUT_WIDTH_MSB:PUT_WIDTH_LSB];
            width_cui_q <= PUT_WIDTH_CUI[PUT_TX_EMPH_RST[PUT_WIDTH_MSB:PUT_WIDTH_LSB]];
            level_q <= PUT_TX_EMPH_RST[PUT_LEVEL_MSB:PUT_LEVEL_LSB];
            level_cdb_q <= PUT_LEVEL_CDB[PUT_TX_EMPH_RST[PUT_LEVEL_MSB:PUT_LEVEL_LSB]];
            drive_q <= PUT_RX_ADJ_RST[PUT_DRIVE_MSB:PUT_DRIVE_LSB];
            drive_ma_q <= PUT_DRIVE_MA[PUT_RX_ADJ_RST[PUT_DRIVE_MSB:PUT_DRIVE_LSB]];
            eq_q <= PUT_RX_ADJ_RST[PUT_EQ_MSB:PUT_EQ_LSB];
            eq_cdb_q <= PUT_EQ_CDB[PUT_RX_ADJ_RST[PUT_EQ_MSB:PUT_EQ_LSB]];
        end else begin
            chg_q <= chg_d;
            pe_on_q <= pe_on_d;
            width_q <= width_d;
            width_cui_q <= width_cui_d;
            level_q <= level_d;
            level_cdb_q <= level_cdb_d;
            drive_q <= drive_d;
            drive_ma_q <= drive_ma_d;
            eq_q <= eq_d;
            eq_cdb_q <= eq_cdb_d;
        end
    end

    assign port1_charging_method1_enable_out = chg_q;
    assign port1_hs_tx_emphasis_on_out = pe_on_q;
    assign port1_hs_tx_emphasis_width_out = width_q;
    assign emphasis_width_parameter_out = width_cui_q;
    assign port1_hs_tx_emphasis_level_out = level_q;
    assign emphasis_level_parameter_out = level_cdb_q;
    assign open_drain_drive_strength_out = drive_q;
    assign drive_current_ma_out = drive_ma_q;
    assign port1_rx_equalizer_level_out = eq_q;
    assign rx_equalizer_cdb_out = eq_cdb_q;

endmodule

`default_nettype wire

// File: rtl/put_pkg.sv
/*
 * Constants for the port-1 USB tuning register pair: offsets, reset
 * values, field positions and decode tables for the analog settings.
 * Assumes a single 100 MHz clock domain and byte-wide registers.
 */
package put_pkg;

    localparam int PUT_DW = 8;
    localparam int PUT_AW = 8;

    // Register offsets
    localparam logic [7:0] PUT_TX_EMPH_OFS = 8'h71;
    localparam logic [7:0] PUT_RX_ADJ_OFS = 8'h72;

    // Reset values
    localparam logic [7:0] PUT_TX_EMPH_RST = 8'h39;
    localparam logic [7:0] PUT_RX_ADJ_RST = 8'h92;
    localparam logic [7:0] PUT_UNMAPPED_RD = 8'h00;

    // Emphasis register fields
    localparam int PUT_CHG_BIT = 6;
    localparam int PUT_WIDTH_LSB = 4;
    localparam int PUT_WIDTH_MSB = 5;
    localparam int PUT_PE_ON_BIT = 3;
    localparam int PUT_LEVEL_LSB = 0;
    localparam int PUT_LEVEL_MSB = 2;

    // Receive adjust register fields
    localparam int PUT_DRIVE_LSB = 6;
    localparam int PUT_DRIVE_MSB = 7;
    localparam int PUT_EQ_LSB = 0;
    localparam int PUT_EQ_MSB = 2;
    localparam logic [7:0] PUT_DRIVE_MASK = 8'hc0;
    localparam logic [7:0] PUT_ALL_MASK = 8'hff;
    localparam logic [7:0] PUT_NO_MASK = 8'h00;

    // Emphasis width in hundredths of a unit interval
    localparam logic [6:0] PUT_WIDTH_CUI [4] = '{7'h23, 7'h2d, 7'h37, 7'h41};
    // Emphasis level in hundredths of a dB
    localparam logic [8:0] PUT_LEVEL_CDB [8] = '{9'h032, 9'h05a, 9'h078, 9'h0aa,
                                                 9'h0d2, 9'h0fa, 9'h140, 9'h190};
    // Receive equalizer in hundredths of a dB
    localparam logic [8:0] PUT_EQ_CDB [8] = '{9'h006, 9'h03a, 9'h06d, 9'h09c,
                                              9'h0e2, 9'h10b, 9'h12f, 9'h14f};
    // Open-drain drive in mA
    localparam logic [3:0] PUT_DRIVE_MA [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

endpackage

// File: rtl/put_cfg_reg.sv
/*
 * One byte-wide configuration register with a constant reset value,
 * a factory value load and two masked write ports (first port wins).
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module put_cfg_reg
    import put_pkg::*;
#(
    parameter logic [PUT_DW-1:0] RESET_VAL = 8'h00
) (
    input wire logic sys_clk_in,               // System clock
    input wire logic rst_n_in,                 // Synchronous reset, active low
    input wire logic load_in,                  // Factory value load strobe
    input wire logic [PUT_DW-1:0] load_val_in, // Factory value
    input wire logic a_wr_in,                  // Port A write strobe
    input wire logic [PUT_DW-1:0] a_mask_in,   // Port A bit mask
    input wire logic [PUT_DW-1:0] a_data_in,   // Port A data
    input wire logic b_wr_in,                  // Port B write strobe
    input wire logic [PUT_DW-1:0] b_mask_in,   // Port B bit mask
    input wire logic [PUT_DW-1:0] b_data_in,   // Port B data
    output logic [PUT_DW-1:0] value_out        // Stored value
);

    logic [PUT_DW-1:0] val_q;
    logic [PUT_DW-1:0] val_d;

    // Software writes beat a factory load in the same cycle
    always_comb begin
        val_d = val_q;
        if (load_in) begin
            val_d = load_val_in;
        end
        if (b_wr_in) begin
            val_d = (val_d & ~b_mask_in) | (b_data_in & b_mask_in);
        end
        if (a_wr_in) begin
            val_d = (val_d & ~a_mask_in) | (a_data_in & a_mask_in);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            val_q <= RESET_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign value_out = val_q;

endmodule

`default_nettype wire

// File: tb/put_tuning_sva.sv
/* Port checker for the port-1 tuning register bank.
   Bound to every put_tuning_regs instance; single clock domain. */
`timescale 1ns/10ps
`default_nettype none
module put_tuning_sva
    import put_pkg::*;
(
    input wire logic sys_clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic ser_rd_in, // Read strobe
    input wire logic ser_wr_in, // Write strobe
    input wire logic ser_rvalid_out, // Read valid
    input wire logic [7:0] link_addr_in, // Link offset
    input wire logic link_wr_in, // Link write
    input wire logic [7:0] link_wdata_in, // Link data
    input wire logic link_wr_taken_out, // Link taken
    input wire logic repeater1_enable_in, // Repeater on
    input wire logic otp_load_in, // Factory load
    input wire logic chirp_active_in, // Chirp
    input wire logic port1_charging_method1_enable_out, // Charging
    input wire logic port1_hs_tx_emphasis_on_out, // Emphasis on
    input wire logic [1:0] port1_hs_tx_emphasis_width_out, // Width
    input wire logic [6:0] emphasis_width_parameter_out, // Width UI
    input wire logic [2:0] port1_hs_tx_emphasis_level_out, // Level
    input wire logic [8:0] emphasis_level_parameter_out, // Level dB
    input wire logic [1:0] open_drain_drive_strength_out, // Drive
    input wire logic [3:0] drive_current_ma_out, // Drive mA
    input wire logic [2:0] port1_rx_equalizer_level_out, // EQ
    input wire logic [8:0] rx_equalizer_cdb_out // EQ dB
);
    logic [1:0] link_drive;
    assign link_drive = link_wdata_in[7:6];
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_read_answer: assert property (ser_rd_in |=> ser_rvalid_out)
        else $error("read not answered");
    a_no_stray_valid: assert property (ser_rvalid_out |-> $past(ser_rd_in))
        else $error("read valid without read");
    a_chirp_mutes: assert property (chirp_active_in |=> !port1_hs_tx_emphasis_on_out)
        else $error("emphasis during chirp");
    a_width_decode: assert property (emphasis_width_parameter_out == PUT_WIDTH_CUI[port1_hs_tx_emphasis_width_out])
        else $error("width decode");
    a_level_decode: assert property (emphasis_level_parameter_out == PUT_LEVEL_CDB[port1_hs_tx_emphasis_level_out])
        else $error("level decode");
    a_drive_decode: assert property (drive_current_ma_out == PUT_DRIVE_MA[open_drain_drive_strength_out])
        else $error("drive decode");
    a_eq_decode: assert property (rx_equalizer_cdb_out == PUT_EQ_CDB[port1_rx_equalizer_level_out])
        else $error("equalizer decode");
    a_link_gate: assert property (link_wr_taken_out == (link_wr_in && repeater1_enable_in && link_addr_in == PUT_RX_ADJ_OFS))
        else $error("link taken wrong");
    a_link_drive: assert property (link_wr_taken_out && !ser_wr_in && !otp_load_in |-> ##2 open_drain_drive_strength_out == $past(link_drive, 2))
        else $error("link drive not applied");
    a_reset_fields: assert property ($rose(rst_n_in) |-> !port1_charging_method1_enable_out && port1_hs_tx_emphasis_width_out == 2'h3 && port1_hs_tx_emphasis_level_out == 3'h1 && open_drain_drive_strength_out == 2'h2 && port1_rx_equalizer_level_out == 3'h2)
        else $error("reset fields wrong");
    c_link: cover property (link_wr_taken_out);
    c_chirp: cover property (chirp_active_in ##1 !port1_hs_tx_emphasis_on_out);
    c_factory: cover property (otp_load_in);
endmodule
bind put_tuning_regs put_tuning_sva u_put_tuning_sva (.sys_clk_in, .rst_n_in, .ser_rd_in,
    .ser_wr_in, .ser_rvalid_out, .link_addr_in, .link_wr_in, .link_wdata_in, .link_wr_taken_out,
    .repeater1_enable_in, .otp_load_in, .chirp_active_in, .port1_charging_method1_enable_out,
    .port1_hs_tx_emphasis_on_out, .port1_hs_tx_emphasis_width_out, .emphasis_width_parameter_out,
    .port1_hs_tx_emphasis_level_out, .emphasis_level_parameter_out, .open_drain_drive_strength_out,
    .drive_current_ma_out, .port1_rx_equalizer_level_out, .rx_equalizer_cdb_out);
`default_nettype wire

// File: tb/put_host_model.sv
/* Host model driving the serial and link register ports.
   Tasks are called from tb; every change lands on a falling edge. */
`timescale 1ns/10ps
`default_nettype none
module put_host_model
    import put_pkg::*;
(
    input wire logic sys_clk_in, // Clock
    input wire logic [7:0] rdata_in, // Read data
    input wire logic rvalid_in, // Read valid
    output logic [7:0] addr_out, // Serial offset
    output logic wr_out, // Serial write
    output logic rd_out, // Serial read
    output logic [7:0] wdata_out, // Serial data
    output logic [7:0] laddr_out, // Link offset
    output logic lwr_out, // Link write
    output logic [7:0] lwdata_out // Link data
);
    initial begin
        {wr_out, rd_out, lwr_out} = 3'h0;
        {addr_out, wdata_out, laddr_out, lwdata_out} = 32'h0000_0000;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
        @(negedge sys_clk_in);
        // Idle bus never repeats the last byte
        {addr_out, wdata_out, wr_out} = {~a, ~d, 1'b0};
    endtask
    task automatic lwr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        {laddr_out, lwdata_out, lwr_out} = {a, d, 1'b1};
        @(negedge sys_clk_in);
        {laddr_out, lwdata_out, lwr_out} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge sys_clk_in);
        {addr_out, rd_out} = {a, 1'b1};
        @(negedge sys_clk_in);
        {addr_out, rd_out} = {~a, 1'b0};
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rvalid_in === 1'b1) begin
                d = rdata_in;
                ok = 1'b1;
            end else begin
                @(negedge sys_clk_in);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
/* Self-checking bench for put_tuning_regs with a host model.
   Assumes the bind in put_tuning_sva.sv is compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module tb
    import put_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, rep_en = 1'b0, otp_ld = 1'b0, chirp = 1'b0;
    logic [7:0] otp_tx = 8'h00, otp_rx = 8'h00, a, d, t, r, rdata, laddr, lwdata;
    logic [7:0] addr, wdata;
    logic wr, rd, lwr, rvalid, chg, pe_on, taken;
    int n_taken = 0;
    logic [1:0] w, ds;
    logic [2:0] lv, eq;
    logic [6:0] wp;
    logic [8:0] lp, eqd;
    logic [3:0] ma;
    logic [31:0] seed = 32'h0001_5638;
    int n_errors = 0, tests_run = 0;
    always #5 clk = ~clk;
    put_host_model u_put_host_model (.sys_clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata), .laddr_out(laddr),
        .lwr_out(lwr), .lwdata_out(lwdata));
    put_tuning_regs u_put_tuning_regs (.sys_clk_in(clk), .rst_n_in(rst_n), .ser_addr_in(addr),
        .ser_wr_in(wr), .ser_rd_in(rd), .ser_wdata_in(wdata), .ser_rdata_out(rdata),
        .ser_rvalid_out(rvalid), .link_addr_in(laddr), .link_wr_in(lwr), .link_wdata_in(lwdata),
        .link_wr_taken_out(taken), .repeater1_enable_in(rep_en), .otp_load_in(otp_ld),
        .otp_tx_emph_in(otp_tx), .otp_rx_adj_in(otp_rx), .chirp_active_in(chirp),
        .port1_charging_method1_enable_out(chg), .port1_hs_tx_emphasis_on_out(pe_on),
        .port1_hs_tx_emphasis_width_out(w), .emphasis_width_parameter_out(wp),
        .port1_hs_tx_emphasis_level_out(lv), .emphasis_level_parameter_out(lp),
        .open_drain_drive_strength_out(ds), .drive_current_ma_out(ma),
        .port1_rx_equalizer_level_out(eq), .rx_equalizer_cdb_out(eqd));
    // Count link writes the design reports as applied
    always @(posedge clk) begin
        if (taken === 1'b1) begin
            n_taken <= n_taken + 1;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic report_and_stop;
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] ra, input logic [7:0] e);
        logic [7:0] v;
        bit ok;
        u_put_host_model.rd(ra, v, ok);
        if (!ok) begin
            n_errors++;
            report_and_stop;
        end else begin
            chk("rdata", 9'(e), 9'(v));
        end
    endtask
    task automatic fchk;
        chk("chg", 9'(t[6]), 9'(chg));
        chk("width", 9'(t[5:4]), 9'(w));
        chk("width_ui", 9'(35 + 10 * t[5:4]), 9'(wp));
        chk("pe_on", 9'(t[3]), 9'(pe_on));
        chk("level", 9'(t[2:0]), 9'(lv));
        chk("level_db", PUT_LEVEL_CDB[t[2:0]], lp);
        chk("drive", 9'(r[7:6]), 9'(ds));
        chk("drive_ma", 9'(PUT_DRIVE_MA[r[7:6]]), 9'(ma));
        chk("eq", 9'(r[2:0]), 9'(eq));
        chk("eq_db", PUT_EQ_CDB[r[2:0]], eqd);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        {t, r} = 16'h3992;
        rchk(8'h71, t);
        rchk(8'h72, r);
        fchk();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end
    initial begin
        do_reset();
        u_put_host_model.wr(8'h73, 8'h00);
        fchk();
        rchk(8'h70, 8'h00);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            a = seed[8] ? 8'h71 : 8'h72;
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : seed[7:0];
            if (a == 8'h71) d[7] = 1'b0;
            else d[5:3] = 3'h2;
            u_put_host_model.wr(a, d);
            if (a == 8'h71) t = d;
            else r = d;
            rchk(a, d);
            fchk();
        end
        t = 8'h3f;
        u_put_host_model.wr(8'h71, t);
        chirp = 1'b1;
        repeat (2) @(negedge clk);
        chk("pe_on", 9'h000, 9'(pe_on));
        chirp = 1'b0;
        repeat (2) @(negedge clk);
        chk("pe_on", 9'h001, 9'(pe_on));
        u_put_host_model.lwr(8'h72, 8'h00);
        rchk(8'h72, r);
        rep_en = 1'b1;
        u_put_host_model.lwr(8'h71, 8'h00);
        rchk(8'h72, r);
        u_put_host_model.lwr(8'h72, 8'h40);
        r[7:6] = 2'h1;
        rchk(8'h72, r);
        chk("taken", 9'h001, 9'(n_taken));
        fchk();
        seed = lfsr(seed);
        // Reserved bits kept so the read-back is meaningful
        otp_tx = {1'b0, seed[6:0]};
        otp_rx = {seed[15:14], 3'h2, seed[10:8]};
        otp_ld = 1'b1;
        @(negedge clk);
        otp_ld = 1'b0;
        {t, r} = {otp_tx, otp_rx};
        rchk(8'h71, t);
        rchk(8'h72, r);
        fchk();
        do_reset();
        report_and_stop;
    end
endmodule
`default_nettype wire
